// >>> core/pcsc_consts.svh
`ifndef PCSC_CONSTS_SVH
`define PCSC_CONSTS_SVH
`define PCSC_REG_INDEX 7'h7F
`define PCSC_BIT_TYPE_HI 12
`define PCSC_BIT_TYPE_LO 8
`define PCSC_BIT_LOCK 7
`define PCSC_BIT_NEST 6
`define PCSC_BIT_INTR 5
`define PCSC_BIT_HIT 4
`define PCSC_BIT_REFRESH 3
`define PCSC_BIT_FLUSH 2
`define PCSC_BIT_ENABLE 1
`define PCSC_BIT_FORCE 0
`define PCSC_RESET_VALUE 32'h0000_0000
`endif

// >>> core/pcsc_pkg.sv
package pcsc_pkg;
  typedef struct packed {
    logic valid;
    logic dStream;
    logic iStream;
    logic ioSpace;
    logic isWrite;
    logic isInval;
    logic isNop;
  } pcsc_ref_t;
  typedef struct packed {
    logic valid;
    logic machineCheck;
    logic interrupt;
    logic [4:0] errType;
    logic tagParity;
    logic dataParity;
  } pcsc_err_t;
endpackage

// >>> core/pcsc_status_control.sv
// Operation
// - Machine-check error sets first_error_lock and freezes error type and address.
// - Machine check while locked sets nested_error_flag; first error info kept.
// - Interrupt-reported error sets the interrupt flag at priority level 1A.
// - Interrupt error latches type only if interrupt and lock both clear.
// - Any error flag disables the cache without flush or enable change.
// - Error flags clear on reset and on write of one.
// - Hit bit captures comparator on data-stream read, write, invalidate; reset clears.
// - Refresh enable runs refresh, counter and timer; clear stops all.
// - Flush bit clears all valid bits, self-clears next cycle, reads zero.
// - Flush and enable in one write are both accepted.
// - Enabled cache caches both streams, reports parity; never caches I/O.
// - Disabled cache turns every reference into a miss; reset clears enable.
// - Force-hit forces hits, writes still go out, I/O unaffected.
// - Force-hit suppresses tag parity on data-stream cycles and data parity on data-stream reads only.
// - Error type bits update only while register not locked.
`timescale 1ns/1ps
`include "pcsc_consts.svh"
module pcsc_status_control #(
  parameter int REG_INDEX_W = 7,
  parameter int ADDR_W = 32
) (
  input wire logic sys_clk,
  input wire logic reset,
  // Privileged register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [REG_INDEX_W-1:0] regIndex,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regRvalid,
  // Reference and error reports from the core
  input wire pcsc_pkg::pcsc_ref_t refIn,
  input wire logic [ADDR_W-1:0] refAddr,
  input wire logic tagCompare,
  input wire pcsc_pkg::pcsc_err_t errIn,
  // Toward arrays, refresh logic and the core
  output logic cacheHit,
  output logic cacheLookup,
  output logic writeThrough,
  output logic flushValid,
  output logic refreshStep,
  output logic refreshCountEn,
  output logic refreshTimerEn,
  output logic parityReportEn,
  output logic intRequest,
  output logic machineCheck,
  output logic [ADDR_W-1:0] errorAddress
);

  // Refuse an index too narrow for the register number
  if (REG_INDEX_W < 7 || ADDR_W < 1) begin : g_bad_params
    $error("pcsc_status_control: unsupported parameter values");
  end

  localparam logic [REG_INDEX_W-1:0] REG_INDEX = REG_INDEX_W'(`PCSC_REG_INDEX);

  logic firstErrorLock;
  logic nestedErrorFlag;
  logic intrFlag;
  logic hitLatch;
  logic refreshOn;
  logic primaryStoreOn;
  logic forceHit;
  logic flushPulse;
  logic [4:0] errType;
  logic [ADDR_W-1:0] errAddr;

  logic regSel;
  logic wrSel;
  logic anyFlag;
  logic cacheActive;
  logic errAccepted;
  logic mcErr;
  logic intErr;
  logic dAnyCycle;
  logic dRead;
  logic tagParityErr;
  logic dataParityErr;
  logic parityErr;
  logic busErr;

  // --------------------------------------------------------------
  // Decode and error qualification
  // --------------------------------------------------------------
  assign regSel = regIndex == REG_INDEX;
  assign wrSel = regWrite && regSel;
  assign anyFlag = firstErrorLock || nestedErrorFlag || intrFlag;
  assign cacheActive = primaryStoreOn && !anyFlag;
  // Reference kinds that the parity masking singles out
  assign dAnyCycle = refIn.valid && refIn.dStream;
  assign dRead = dAnyCycle && !refIn.isWrite && !refIn.isInval;
  // Force-hit hides tag parity on data cycles, data parity on data reads
  assign tagParityErr = errIn.tagParity && !(forceHit && dAnyCycle);
  assign dataParityErr = errIn.dataParity && !(forceHit && dRead);
  // Array parity is only reported while the cache runs
  assign parityErr = (tagParityErr || dataParityErr) && cacheActive;
  // Local-bus errors carry no parity flag and always pass
  assign busErr = !errIn.tagParity && !errIn.dataParity;
  assign errAccepted = errIn.valid && (busErr || parityErr);
  assign mcErr = errAccepted && errIn.machineCheck;
  assign intErr = errAccepted && errIn.interrupt;

  // --------------------------------------------------------------
  // Error flags
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      firstErrorLock <= 1'b0;
    end else if (mcErr) begin
      firstErrorLock <= 1'b1;
    end else if (wrSel && regWdata[`PCSC_BIT_LOCK]) begin
      firstErrorLock <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nestedErrorFlag <= 1'b0;
    end else if (mcErr && firstErrorLock) begin
      nestedErrorFlag <= 1'b1;
    end else if (wrSel && regWdata[`PCSC_BIT_NEST]) begin
      nestedErrorFlag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      intrFlag <= 1'b0;
    end else if (intErr) begin
      intrFlag <= 1'b1;
    end else if (wrSel && regWdata[`PCSC_BIT_INTR]) begin
      intrFlag <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Error type and address latch
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      errType <= 5'h0_0;
    end else if (mcErr && !firstErrorLock) begin
      errType <= errIn.errType;
    end else if (intErr && !intrFlag && !firstErrorLock) begin
      errType <= errIn.errType;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      errAddr <= '0;
    end else if (mcErr && !firstErrorLock && !refIn.isWrite) begin
      errAddr <= refAddr;
    end
  end

  // --------------------------------------------------------------
  // Control bits
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      refreshOn <= 1'b0;
      primaryStoreOn <= 1'b0;
      forceHit <= 1'b0;
    end else if (wrSel) begin
      refreshOn <= regWdata[`PCSC_BIT_REFRESH];
      primaryStoreOn <= regWdata[`PCSC_BIT_ENABLE];
      forceHit <= regWdata[`PCSC_BIT_FORCE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flushPulse <= 1'b0;
    end else begin
      flushPulse <= wrSel && regWdata[`PCSC_BIT_FLUSH];
    end
  end

  // --------------------------------------------------------------
  // Hit capture
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hitLatch <= 1'b0;
    end else if (refIn.valid && refIn.dStream) begin
      hitLatch <= tagCompare;
    end
  end

  // --------------------------------------------------------------
  // Cache array controls
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cacheLookup <= 1'b0;
    end else begin
      cacheLookup <= refIn.valid && !refIn.ioSpace && cacheActive;
    end
  end

  // --------------------------------------------------------------
  // Hit result toward the arrays
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cacheHit <= 1'b0;
    end else if (!refIn.valid || refIn.ioSpace || !cacheActive) begin
      cacheHit <= 1'b0;
    end else if (forceHit) begin
      cacheHit <= 1'b1;
    end else begin
      cacheHit <= tagCompare;
    end
  end

  // --------------------------------------------------------------
  // Write path
  // --------------------------------------------------------------
  // Writes always reach memory, forced hit or not
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      writeThrough <= 1'b0;
    end else begin
      writeThrough <= refIn.valid && refIn.isWrite;
    end
  end

  // --------------------------------------------------------------
  // Flush strobe
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flushValid <= 1'b0;
    end else begin
      flushValid <= flushPulse;
    end
  end

  // --------------------------------------------------------------
  // Refresh controls
  // --------------------------------------------------------------
  // All three stand still while refresh is off
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      refreshStep <= 1'b0;
      refreshCountEn <= 1'b0;
      refreshTimerEn <= 1'b0;
    end else begin
      refreshStep <= refreshOn && refIn.isNop;
      refreshCountEn <= refreshOn && refIn.isNop;
      refreshTimerEn <= refreshOn && !refIn.isNop && !wrSel;
    end
  end

  // --------------------------------------------------------------
  // Parity reporting
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      parityReportEn <= 1'b0;
    end else begin
      parityReportEn <= cacheActive;
    end
  end

  // --------------------------------------------------------------
  // Error reporting to the core
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      intRequest <= 1'b0;
      machineCheck <= 1'b0;
    end else begin
      intRequest <= intrFlag;
      machineCheck <= mcErr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      errorAddress <= '0;
    end else begin
      errorAddress <= errAddr;
    end
  end

  // --------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regRdata <= `PCSC_RESET_VALUE;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead && regSel) begin
        regRdata <= {19'h0_0000, errType, firstErrorLock, nestedErrorFlag, intrFlag,
                     hitLatch, refreshOn, 1'b0, primaryStoreOn, forceHit};
      end else begin
        regRdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// >>> tb/pcsc_core_model.sv
`timescale 1ns/1ps
module pcsc_core_model (
  input wire logic sys_clk,
  input wire logic regRvalid,
  input wire logic [31:0] regRdata,
  output logic regWrite,
  output logic regRead,
  output logic [6:0] regIndex,
  output logic [31:0] regWdata,
  output pcsc_pkg::pcsc_ref_t refIn,
  output logic [31:0] refAddr,
  output logic tagCompare,
  output pcsc_pkg::pcsc_err_t errIn
);
  logic en = 1'b0;
  initial begin
    {regWrite, regRead, regIndex, regWdata, refIn, refAddr, tagCompare, errIn} = '0;
  end
  task automatic wr(input logic [31:0] d);
    @(negedge sys_clk);
    if (d[0] && !d[1]) d[0] = 1'b0;
    if (d[1] && !en) d[2] = 1'b1;
    en = d[1];
    regIndex <= 7'h7F;
    regWdata <= d;
    regWrite <= 1'b1;
    @(negedge sys_clk);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask
  task automatic rd(output logic [31:0] q);
    @(negedge sys_clk);
    regIndex <= 7'h7F;
    regRead <= 1'b1;
    @(negedge sys_clk);
    regRead <= 1'b0;
    for (int n = 0; n < 4 && !regRvalid; n++) @(negedge sys_clk);
    q = regRdata;
  endtask
  task automatic err(input logic mc, input logic [4:0] t);
    @(negedge sys_clk);
    errIn <= '{1'b1, mc, !mc, t, 1'b0, 1'b0};
    @(negedge sys_clk);
    errIn <= '0;
  endtask
  task automatic nop();
    @(negedge sys_clk);
    refIn <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    @(negedge sys_clk);
    refIn <= '0;
  endtask
  task automatic rf(input logic io, input logic hit);
    @(negedge sys_clk);
    refIn <= '{1'b1, 1'b1, 1'b0, io, 1'b0, 1'b0, 1'b0};
    tagCompare <= hit;
    refAddr <= ~refAddr;
    @(negedge sys_clk);
    refIn <= '0;
  endtask
endmodule

// >>> tb/pcsc_status_control_chk.sv
`timescale 1ns/1ps
module pcsc_status_control_chk #(
  parameter int REG_INDEX_W = 7
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [REG_INDEX_W-1:0] regIndex,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic regRvalid,
  input wire pcsc_pkg::pcsc_ref_t refIn,
  input wire pcsc_pkg::pcsc_err_t errIn,
  input wire logic cacheHit,
  input wire logic flushValid,
  input wire logic parityReportEn,
  input wire logic intRequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic clrInt;
  assign clrInt = regWrite && regIndex == 7'h7F && regWdata[5];
  sequence flush_wr;
    regWrite && regIndex == 7'h7F && regWdata[2];
  endsequence
  sequence flush_out;
    ##2 flushValid;
  endsequence
  rd_answer_a: assert property (regRead |=> regRvalid) else $error("read unanswered");
  rd_zero_a: assert property (regRvalid |-> regRdata[31:13] == 0 && !regRdata[2]) else $error("bad zero bits");
  flush_pulse_a: assert property (flush_wr |-> flush_out) else $error("no flush pulse");
  int_flag_a: assert property (errIn.valid && errIn.interrupt |-> ##[1:2] intRequest) else $error("no intr");
  err_off_a: assert property (errIn.valid |-> ##[1:2] !parityReportEn) else $error("cache not off");
  io_miss_a: assert property (refIn.valid && refIn.ioSpace |=> !cacheHit) else $error("io hit");
  int_hold_a: assert property (intRequest && !clrInt && !$past(clrInt) |=> intRequest) else $error("intr lost");
  rst_clear_a: assert property (disable iff (1'b0) reset |=> !intRequest && !parityReportEn) else $error("reset");
endmodule
bind pcsc_status_control pcsc_status_control_chk #(.REG_INDEX_W(REG_INDEX_W)) chk (.sys_clk(sys_clk),
  .reset(reset), .regWrite(regWrite), .regRead(regRead), .regIndex(regIndex), .regWdata(regWdata),
  .regRdata(regRdata), .regRvalid(regRvalid), .refIn(refIn), .errIn(errIn), .cacheHit(cacheHit),
  .flushValid(flushValid), .parityReportEn(parityReportEn), .intRequest(intRequest));

// >>> tb/pcsc_status_control_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s %h %h", nm, e, g); end end
module pcsc_status_control_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic regWrite, regRead, regRvalid, tagCompare, cacheHit, flushValid, refreshCountEn, parityReportEn, intRequest;
  logic cacheLookup, refreshStep, refreshTimerEn, machineCheck;
  logic [6:0] regIndex;
  logic [31:0] regWdata, regRdata, refAddr, q, a, errorAddress;
  pcsc_pkg::pcsc_ref_t refIn;
  pcsc_pkg::pcsc_err_t errIn;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2 sys_clk = ~sys_clk;
  pcsc_core_model core (.sys_clk(sys_clk), .regRvalid(regRvalid), .regRdata(regRdata), .regWrite(regWrite),
    .regRead(regRead), .regIndex(regIndex), .regWdata(regWdata), .refIn(refIn), .refAddr(refAddr),
    .tagCompare(tagCompare), .errIn(errIn));
  pcsc_status_control dut (.sys_clk(sys_clk), .reset(reset), .regWrite(regWrite), .regRead(regRead),
    .regIndex(regIndex), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .refIn(refIn),
    .refAddr(refAddr), .tagCompare(tagCompare), .errIn(errIn), .cacheHit(cacheHit), .cacheLookup(cacheLookup),
    .writeThrough(), .flushValid(flushValid), .refreshStep(refreshStep), .refreshCountEn(refreshCountEn),
    .refreshTimerEn(refreshTimerEn), .parityReportEn(parityReportEn), .intRequest(intRequest),
    .machineCheck(machineCheck), .errorAddress(errorAddress));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    core.rd(q);
    `CHK("reset", 32'h0000_0000, q)
    core.wr(32'h0000_0006);
    core.rd(q);
    `CHK("flush enable", 32'h0000_0002, q)
    core.wr(32'h0000_001F);
    @(negedge sys_clk);
    `CHK("flush pulse", 1'b1, flushValid)
    core.rf(1'b1, 1'b0);
    `CHK("io miss", 1'b0, cacheHit)
    `CHK("io lookup", 1'b0, cacheLookup)
    core.rf(1'b0, 1'b0);
    `CHK("forced hit", 1'b1, cacheHit)
    `CHK("timer on", 1'b1, refreshTimerEn)
    core.rf(1'b0, 1'b1);
    core.rd(q);
    `CHK("hit force", 32'h0000_001B, q)
    core.nop();
    `CHK("refresh on", 1'b1, refreshCountEn)
    `CHK("refresh step", 1'b1, refreshStep)
    core.err(1'b0, 5'h03);
    core.rd(q);
    `CHK("intr", 32'h0000_033B, q)
    `CHK("parity off", 1'b0, parityReportEn)
    core.rf(1'b0, 1'b1);
    `CHK("flag miss", 1'b0, cacheHit)
    core.err(1'b1, 5'h05);
    `CHK("machine check", 1'b1, machineCheck)
    a = refAddr;
    core.rd(q);
    `CHK("lock", 32'h0000_05BB, q)
    `CHK("error address", a, errorAddress)
    core.rf(1'b0, 1'b1);
    core.err(1'b1, 5'h11);
    core.wr(32'h0000_000B);
    core.rd(q);
    `CHK("nested", 32'h0000_05FB, q)
    `CHK("first address", a, errorAddress)
    core.wr(32'h0000_00EB);
    core.rd(q);
    `CHK("flags clear", 32'h0000_001B, q & 32'h0000_00FF)
    core.wr(32'h0000_0000);
    core.rd(q);
    `CHK("all off", 32'h0000_0010, q & 32'h0000_00FF)
    core.nop();
    `CHK("refresh off", 1'b0, refreshCountEn)
    `CHK("step off", 1'b0, refreshStep)
    stop_test();
  end
endmodule
